// ### pkg/msg_sig_pkg.sv
package msg_sig_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_EVT = 8'h08;
   localparam logic [7:0] ADDR_MASK = 8'h0C;
   // Control fields
   localparam int CTRL_ROOT_BIT = 0;
   localparam int CTRL_AER_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   // Event status / mask fields
   localparam int EVT_W = 6;
   localparam int EVT_COR = 0;
   localparam int EVT_NONFATAL = 1;
   localparam int EVT_FATAL = 2;
   localparam int EVT_TURNOFF_RX = 3;
   localparam int EVT_TOACK_RX = 4;
   localparam int EVT_INTX_CHG = 5;
   localparam logic [5:0] EVT_RESET = 6'h0;
   localparam logic [5:0] MASK_RESET = 6'h0;
   // Message codes
   localparam logic [7:0] MSG_ASSERT_A = 8'h20;
   localparam logic [7:0] MSG_ASSERT_B = 8'h21;
   localparam logic [7:0] MSG_ASSERT_C = 8'h22;
   localparam logic [7:0] MSG_ASSERT_D = 8'h23;
   localparam logic [7:0] MSG_DEASSERT_A = 8'h24;
   localparam logic [7:0] MSG_DEASSERT_D = 8'h27;
   localparam logic [7:0] MSG_TURN_OFF = 8'h19;
   localparam logic [7:0] MSG_TO_ACK = 8'h1B;
   localparam logic [7:0] MSG_ERR_COR = 8'h30;
   localparam logic [7:0] MSG_ERR_NONFATAL = 8'h31;
   localparam logic [7:0] MSG_ERR_FATAL = 8'h33;
   localparam logic [7:0] MSG_CODE_RESET = 8'h00;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int MSI_W = 5;
endpackage

// ### core/evt_irq.sv
`timescale 1ns/100ps
module evt_irq #(
   parameter int W = 6
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] set,
   input wire logic clr_we,
   input wire logic [W-1:0] clr_data,
   input wire logic mask_we,
   input wire logic [W-1:0] mask_data,
   output logic [W-1:0] status,
   output logic [W-1:0] mask,
   output logic irq
);
   logic [W-1:0] status_r, status_nxt, mask_r, mask_nxt;

   always_comb begin
      status_nxt = status_r;
      mask_nxt = mask_r;
      if (clr_we) begin
         status_nxt = status_nxt & ~clr_data;
      end
      // Set wins over a clear in the same cycle
      status_nxt = status_nxt | set;
      if (mask_we) begin
         mask_nxt = mask_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= '0;
         mask_r <= '0;
      end else begin
         status_r <= status_nxt;
         mask_r <= mask_nxt;
      end
   end

   assign status = status_r;
   assign mask = mask_r;
   assign irq = |(status_r & mask_r);

   property p_set_wins;
      @(posedge aclk) disable iff (!aresetn)
         (set != '0) |=> ((status_r & $past(set)) == $past(set));
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event bit lost");
endmodule // evt_irq

// ### core/msg_tx_slot.sv
`timescale 1ns/100ps
module msg_tx_slot #(
   parameter int CW = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic load,
   input wire logic [CW-1:0] load_code,
   input wire logic tx_ready,
   output logic tx_valid,
   output logic [CW-1:0] tx_code
);
   logic valid_r, valid_nxt;
   logic [CW-1:0] code_r, code_nxt;

   always_comb begin
      valid_nxt = valid_r;
      code_nxt = code_r;
      if (valid_r && tx_ready) begin
         valid_nxt = 1'b0;
      end
      if (load && !valid_r) begin
         valid_nxt = 1'b1;
         code_nxt = load_code;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         valid_r <= 1'b0;
         code_r <= '0;
      end else begin
         valid_r <= valid_nxt;
         code_r <= code_nxt;
      end
   end

   assign tx_valid = valid_r;
   assign tx_code = code_r;

   property p_hold;
      @(posedge aclk) disable iff (!aresetn)
         valid_r && !tx_ready |=> valid_r && $stable(code_r);
   endproperty
   a_hold: assert property (p_hold)
      else $error("message dropped before taken");
endmodule // msg_tx_slot

// ### core/msg_signaling.sv
`timescale 1ns/100ps
// Operation
// - As Endpoint only pin A assert/deassert messages are ever sent.
// - As Root Port received INTx messages drive the 4-bit int_status.
// - int_status bit 0..3 map to pins A..D in order.
// - As Root Port a rising turn-off request sends the turn-off message.
// - As Endpoint a rising turn-off request sends the turn-off ack.
// - A Root Port collects received and self-detected error classes.
// - Root Port reports errors by the serr_out flag and an MSI request.
// - serr_out is high while an error is recorded in the error status.
module msg_signaling #(
   parameter int AW = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_msg_valid,
   input wire logic [7:0] rx_msg_code,
   output logic tx_msg_valid,
   output logic [7:0] tx_msg_code,
   input wire logic tx_msg_ready,
   input wire logic app_inta,
   input wire logic pm_turnoff_request,
   input wire logic [2:0] err_detected,
   input wire logic [msg_sig_pkg::MSI_W-1:0] aer_msi_num,
   output logic [3:0] int_status,
   output logic serr_out,
   output logic msi_req,
   output logic [msg_sig_pkg::MSI_W-1:0] msi_num,
   output logic irq
);
   localparam int EW = msg_sig_pkg::EVT_W;
   localparam int MW = msg_sig_pkg::MSI_W;

   logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
   logic [AW-1:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [1:0] ctrl_r, ctrl_nxt;
   logic wr_go, wr_byte0, clr_we, mask_we;
   logic [3:0] intst_r, intst_nxt;
   logic req_d_r, req_d_nxt, to_pend_r, to_pend_nxt;
   logic sent_a_r, sent_a_nxt, msi_req_r, msi_req_nxt;
   logic [MW-1:0] msi_num_r, msi_num_nxt;
   logic root, aer_en, req_rise, slot_load;
   logic [7:0] slot_code;
   logic [EW-1:0] evt_set, evt_status, evt_mask;
   logic [2:0] err_hit;

   assign root = ctrl_r[msg_sig_pkg::CTRL_ROOT_BIT];
   assign aer_en = ctrl_r[msg_sig_pkg::CTRL_AER_BIT];

   // AXI4-Lite write and read channels
   assign s_axi_awready = !aw_hold_r && !bvalid_r;
   assign s_axi_wready = !w_hold_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign wr_go = aw_hold_r && w_hold_r;
   assign wr_byte0 = wr_go && wstrb_r[0];
   assign clr_we = wr_byte0 && (awaddr_r == msg_sig_pkg::ADDR_EVT);
   assign mask_we = wr_byte0 && (awaddr_r == msg_sig_pkg::ADDR_MASK);

   always_comb begin
      aw_hold_nxt = aw_hold_r;
      w_hold_nxt = w_hold_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      ctrl_nxt = ctrl_r;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_hold_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (wr_go) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = msg_sig_pkg::RESP_OKAY;
         if (awaddr_r == msg_sig_pkg::ADDR_CTRL) begin
            ctrl_nxt = wstrb_r[0] ? wdata_r[1:0] : ctrl_r;
         end else if (awaddr_r != msg_sig_pkg::ADDR_STATUS
                      && awaddr_r != msg_sig_pkg::ADDR_EVT
                      && awaddr_r != msg_sig_pkg::ADDR_MASK) begin
            bresp_nxt = msg_sig_pkg::RESP_SLVERR;
         end
      end
   end

   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (s_axi_rvalid && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = msg_sig_pkg::RESP_OKAY;
         rdata_nxt = 32'h0000_0000;
         if (s_axi_araddr == msg_sig_pkg::ADDR_CTRL) begin
            rdata_nxt = {30'h0000_0000, ctrl_r};
         end else if (s_axi_araddr == msg_sig_pkg::ADDR_STATUS) begin
            rdata_nxt = {25'h000_0000, to_pend_r, tx_msg_valid,
               serr_out, intst_r};
         end else if (s_axi_araddr == msg_sig_pkg::ADDR_EVT) begin
            rdata_nxt = {26'h000_0000, evt_status};
         end else if (s_axi_araddr == msg_sig_pkg::ADDR_MASK) begin
            rdata_nxt = {26'h000_0000, evt_mask};
         end else begin
            rresp_nxt = msg_sig_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= msg_sig_pkg::RESP_OKAY;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= msg_sig_pkg::RESP_OKAY;
         ctrl_r <= msg_sig_pkg::CTRL_RESET;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         w_hold_r <= w_hold_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
         ctrl_r <= ctrl_nxt;
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // Message decode, interrupt lines, error collection, transmit choice
   assign req_rise = pm_turnoff_request && !req_d_r;

   always_comb begin
      intst_nxt = intst_r;
      err_hit = 3'h0;
      evt_set = '0;
      if (!root) begin
         intst_nxt = 4'h0;
      end else if (rx_msg_valid && rx_msg_code >= msg_sig_pkg::MSG_ASSERT_A
                   && rx_msg_code <= msg_sig_pkg::MSG_DEASSERT_D) begin
         // Code bits 1:0 pick pin A..D, bit 2 marks deassert
         intst_nxt[rx_msg_code[1:0]] = !rx_msg_code[2];
         evt_set[msg_sig_pkg::EVT_INTX_CHG] = 1'b1;
      end
      if (root) begin
         err_hit = err_detected;
         if (rx_msg_valid) begin
            err_hit[0] |= rx_msg_code == msg_sig_pkg::MSG_ERR_COR;
            err_hit[1] |= rx_msg_code == msg_sig_pkg::MSG_ERR_NONFATAL;
            err_hit[2] |= rx_msg_code == msg_sig_pkg::MSG_ERR_FATAL;
            if (rx_msg_code == msg_sig_pkg::MSG_TO_ACK) begin
               evt_set[msg_sig_pkg::EVT_TOACK_RX] = 1'b1;
            end
         end
      end else if (rx_msg_valid
                   && rx_msg_code == msg_sig_pkg::MSG_TURN_OFF) begin
         evt_set[msg_sig_pkg::EVT_TURNOFF_RX] = 1'b1;
      end
      evt_set[2:0] = err_hit;
   end
   always_comb begin
      req_d_nxt = pm_turnoff_request;
      to_pend_nxt = to_pend_r || req_rise;
      sent_a_nxt = sent_a_r;
      slot_load = 1'b0;
      slot_code = msg_sig_pkg::MSG_CODE_RESET;
      msi_req_nxt = 1'b0;
      msi_num_nxt = msi_num_r;
      if (!tx_msg_valid) begin
         if (to_pend_r || req_rise) begin
            slot_load = 1'b1;
            to_pend_nxt = 1'b0;
            slot_code = root ? msg_sig_pkg::MSG_TURN_OFF
               : msg_sig_pkg::MSG_TO_ACK;
         end else if (!root && app_inta != sent_a_r) begin
            slot_load = 1'b1;
            sent_a_nxt = app_inta;
            slot_code = app_inta ? msg_sig_pkg::MSG_ASSERT_A
               : msg_sig_pkg::MSG_DEASSERT_A;
         end
      end
      if (root && aer_en && err_hit != 3'h0) begin
         msi_req_nxt = 1'b1;
         msi_num_nxt = aer_msi_num;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         intst_r <= 4'h0;
         req_d_r <= 1'b0;
         to_pend_r <= 1'b0;
         sent_a_r <= 1'b0;
         msi_req_r <= 1'b0;
         msi_num_r <= '0;
      end else begin
         intst_r <= intst_nxt;
         req_d_r <= req_d_nxt;
         to_pend_r <= to_pend_nxt;
         sent_a_r <= sent_a_nxt;
         msi_req_r <= msi_req_nxt;
         msi_num_r <= msi_num_nxt;
      end
   end

   assign int_status = intst_r;
   assign serr_out = |evt_status[2:0];
   assign msi_req = msi_req_r;
   assign msi_num = msi_num_r;

   msg_tx_slot #(.CW(8)) u_slot (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(slot_load),
      .load_code(slot_code),
      .tx_ready(tx_msg_ready),
      .tx_valid(tx_msg_valid),
      .tx_code(tx_msg_code)
   );

   evt_irq #(.W(EW)) u_evt (
      .aclk(aclk),
      .aresetn(aresetn),
      .set(evt_set),
      .clr_we(clr_we),
      .clr_data(wdata_r[EW-1:0]),
      .mask_we(mask_we),
      .mask_data(wdata_r[EW-1:0]),
      .status(evt_status),
      .mask(evt_mask),
      .irq(irq)
   );

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_ep_only_a;
      tx_msg_valid && tx_msg_code >= msg_sig_pkg::MSG_ASSERT_A
         && tx_msg_code <= msg_sig_pkg::MSG_DEASSERT_D
      |-> tx_msg_code[1:0] == 2'h0;
   endproperty
   a_ep_only_a: assert property (p_ep_only_a)
      else $error("non-A interrupt message sent");
   property p_rp_assert;
      root && rx_msg_valid && rx_msg_code == msg_sig_pkg::MSG_ASSERT_B
      |=> int_status == ($past(int_status) | 4'h2);
   endproperty
   a_rp_assert: assert property (p_rp_assert)
      else $error("assert B did not set bit 1");
   property p_rp_deassert;
      root && rx_msg_valid && rx_msg_code == msg_sig_pkg::MSG_DEASSERT_D
      |=> int_status == ($past(int_status) & 4'h7);
   endproperty
   a_rp_deassert: assert property (p_rp_deassert)
      else $error("deassert D did not clear bit 3");
   property p_rp_turnoff;
      root && req_rise && !tx_msg_valid
      |=> tx_msg_valid && tx_msg_code == msg_sig_pkg::MSG_TURN_OFF;
   endproperty
   a_rp_turnoff: assert property (p_rp_turnoff)
      else $error("turn-off not sent");
   property p_ep_ack;
      !root && req_rise && !tx_msg_valid
      |=> tx_msg_valid && tx_msg_code == msg_sig_pkg::MSG_TO_ACK;
   endproperty
   a_ep_ack: assert property (p_ep_ack)
      else $error("turn-off ack not sent");
   property p_err_fatal;
      root && rx_msg_valid && rx_msg_code == msg_sig_pkg::MSG_ERR_FATAL
      |=> evt_status[msg_sig_pkg::EVT_FATAL];
   endproperty
   a_err_fatal: assert property (p_err_fatal)
      else $error("fatal error message not collected");
   property p_serr;
      root && rx_msg_valid && rx_msg_code == msg_sig_pkg::MSG_ERR_COR
      |=> serr_out;
   endproperty
   a_serr: assert property (p_serr)
      else $error("serr_out not raised on error");
   property p_msi;
      root && aer_en && err_detected[1]
      |=> msi_req && msi_num == $past(aer_msi_num)
         ##1 (!msi_req || $past(err_hit != 3'h0));
   endproperty
   a_msi: assert property (p_msi)
      else $error("error MSI request wrong");
   property p_no_msi_ep;
      !root |=> !msi_req;
   endproperty
   a_no_msi_ep: assert property (p_no_msi_ep)
      else $error("MSI request outside Root Port");
   property p_bresp;
      wr_go |=> s_axi_bvalid;
   endproperty
   a_bresp: assert property (p_bresp)
      else $error("write answer missing");

   c_turnoff: cover property (root && tx_msg_valid && tx_msg_ready
      && tx_msg_code == msg_sig_pkg::MSG_TURN_OFF);
   c_ack: cover property (!root && tx_msg_valid && tx_msg_ready
      && tx_msg_code == msg_sig_pkg::MSG_TO_ACK);
   c_intx: cover property (int_status == 4'hF);
   c_irq: cover property (irq && serr_out);
endmodule // msg_signaling

// ### dv/link_model.sv
`timescale 1ns/100ps
module link_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic stall,
   input wire logic send,
   input wire logic [7:0] send_code,
   output logic tx_msg_ready,
   output logic rx_msg_valid,
   output logic [7:0] rx_msg_code
);
   // Takes offered messages unless stalled
   // Received code toggles while idle so a stale value never looks valid
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_msg_ready <= 1'b0;
         rx_msg_valid <= 1'b0;
         rx_msg_code <= 8'h00;
      end else begin
         tx_msg_ready <= !stall;
         rx_msg_valid <= send;
         rx_msg_code <= send ? send_code : ~rx_msg_code;
      end
   end
endmodule // link_model

// ### dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   localparam logic [1:0] OK = msg_sig_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = msg_sig_pkg::RESP_SLVERR;
   localparam logic [7:0] CTRL = msg_sig_pkg::ADDR_CTRL;
   localparam logic [7:0] STAT = msg_sig_pkg::ADDR_STATUS;
   localparam logic [7:0] EVT = msg_sig_pkg::ADDR_EVT;
   localparam logic [7:0] MASK = msg_sig_pkg::ADDR_MASK;
   localparam logic [31:0] Z = 32'h0000_0000;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf, int_status, lv;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, tx_msg_valid, tx_msg_ready, rx_msg_valid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] tx_msg_code, rx_msg_code, send_code = 8'h00, c;
   logic app_inta = 1'b0, pm_turnoff_request = 1'b0, stall = 1'b0;
   logic send = 1'b0, serr_out, msi_req, irq;
   logic [2:0] err_detected = 3'h0;
   logic [msg_sig_pkg::MSI_W-1:0] aer_msi_num = 5'h00, msi_num;
   logic [5:0] ev;
   logic [33:0] q_tx[$], q_rd[$], q_msi[$];
   int fails = 0, n_compared = 0, cyc = 0;

   msg_signaling u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_msg_valid,
      .rx_msg_code, .tx_msg_valid, .tx_msg_code, .tx_msg_ready, .app_inta,
      .pm_turnoff_request, .err_detected, .aer_msi_num, .int_status,
      .serr_out, .msi_req, .msi_num, .irq);
   link_model u_link (.aclk, .aresetn, .stall, .send, .send_code,
      .tx_msg_ready, .rx_msg_valid, .rx_msg_code);

   always #5 aclk = ~aclk;
   always @(posedge aclk) stall <= ($urandom_range(0, 3) == 0);

   task automatic chk(input logic [33:0] s, input logic [33:0] e);
      n_compared++;
      if (s !== e) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic wrap_up();
      if (q_tx.size() + q_rd.size() + q_msi.size() != 0)
         fails++;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         wrap_up();
      end
   end

   // Result watcher: oldest note is compared when a result appears
   always @(negedge aclk) begin
      if ((tx_msg_valid & tx_msg_ready) === 1'b1) begin
         chk(34'(q_tx.size() != 0), 34'h1);
         chk(34'(tx_msg_code), q_tx.pop_front());
      end
      if ((s_axi_rvalid & s_axi_rready) === 1'b1) begin
         chk(34'(q_rd.size() != 0), 34'h1);
         chk({s_axi_rresp, s_axi_rdata}, q_rd.pop_front());
      end
      if (msi_req === 1'b1) begin
         chk(34'(q_msi.size() != 0), 34'h1);
         chk(34'(msi_num), q_msi.pop_front());
      end
   end

   task automatic wr(input logic [7:0] a, input logic [5:0] d,
                     input logic [1:0] r);
      logic aw, w, b;
      b = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= 32'(d);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b) begin
         @(negedge aclk);
         aw = s_axi_awvalid & s_axi_awready;
         w = s_axi_wvalid & s_axi_wready;
         b = s_axi_bvalid === 1'b1;
         if (b)
            chk(34'(s_axi_bresp), 34'(r));
         @(posedge aclk);
         if (aw)
            s_axi_awvalid <= 1'b0;
         if (w)
            s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [1:0] r,
                     input logic [31:0] d);
      logic ar, rv;
      rv = 1'b0;
      q_rd.push_back({r, d});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!rv) begin
         @(negedge aclk);
         ar = s_axi_arvalid & s_axi_arready;
         rv = s_axi_rvalid === 1'b1;
         @(posedge aclk);
         if (ar)
            s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask

   task automatic rx(input logic [7:0] code);
      @(posedge aclk);
      send <= 1'b1;
      send_code <= code;
      @(posedge aclk);
      send <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask

   task automatic txw();
      wait (q_tx.size() == 0);
      @(posedge aclk);
   endtask

   initial begin
      void'($urandom(23));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values, unmapped and read-only places
      rd(CTRL, OK, Z);
      rd(EVT, OK, Z);
      rd(MASK, OK, Z);
      rd(8'h10, ERR, Z);
      wr(8'h10, 6'h3f, ERR);
      wr(MASK, 6'h3f, OK);
      rd(MASK, OK, 32'h0000_003f);
      wr(STAT, 6'h3f, OK);
      rd(STAT, OK, Z);
      // Endpoint: pin A messages and turn-off ack under link stalls
      q_tx.push_back(34'(msg_sig_pkg::MSG_ASSERT_A));
      app_inta <= 1'b1;
      txw();
      q_tx.push_back(34'(msg_sig_pkg::MSG_DEASSERT_A));
      app_inta <= 1'b0;
      txw();
      rx(msg_sig_pkg::MSG_ASSERT_B);
      chk(34'(int_status), 34'h0);
      err_detected <= 3'h7;
      @(posedge aclk);
      err_detected <= 3'h0;
      repeat (4) @(posedge aclk);
      chk(34'(serr_out), 34'h0);
      rx(msg_sig_pkg::MSG_TURN_OFF);
      chk(34'(irq), 34'h1);
      rd(EVT, OK, 32'h0000_0008);
      q_tx.push_back(34'(msg_sig_pkg::MSG_TO_ACK));
      pm_turnoff_request <= 1'b1;
      txw();
      pm_turnoff_request <= 1'b0;
      wr(EVT, 6'h08, OK);
      chk(34'(irq), 34'h0);
      // Root Port: turn-off message and INTx decode
      wr(CTRL, 6'h01, OK);
      q_tx.push_back(34'(msg_sig_pkg::MSG_TURN_OFF));
      pm_turnoff_request <= 1'b1;
      txw();
      pm_turnoff_request <= 1'b0;
      lv = 4'h0;
      for (int p = 0; p < 8; p++) begin
         c = (p < 4) ? msg_sig_pkg::MSG_ASSERT_A : msg_sig_pkg::MSG_DEASSERT_A;
         rx(c + 8'(p % 4));
         lv[p % 4] = (p < 4);
         chk(34'(int_status), 34'(lv));
         if (p == 3)
            rd(STAT, OK, 32'h0000_000f);
      end
      rx(msg_sig_pkg::MSG_TO_ACK);
      rd(EVT, OK, 32'h0000_0030);
      wr(EVT, 6'h30, OK);
      // Byte lane 0 off: the write is answered but leaves the mask alone
      s_axi_wstrb <= 4'h0;
      wr(MASK, 6'h00, OK);
      s_axi_wstrb <= 4'hf;
      rd(MASK, OK, 32'h0000_003f);
      // Error with reporting interrupt off: flag only, no MSI request
      err_detected <= 3'h2;
      @(posedge aclk);
      err_detected <= 3'h0;
      repeat (4) @(posedge aclk);
      chk(34'(serr_out), 34'h1);
      rd(EVT, OK, 32'h0000_0002);
      wr(EVT, 6'h02, OK);
      chk(34'(serr_out), 34'h0);
      // Error classes from link and own detection, flag and MSI
      wr(CTRL, 6'h03, OK);
      for (int e = 0; e < 6; e++) begin
         aer_msi_num <= 5'($urandom);
         @(posedge aclk);
         q_msi.push_back(34'(aer_msi_num));
         ev = 6'h01 << (e % 3);
         if (e < 3) begin
            c = (e == 0) ? msg_sig_pkg::MSG_ERR_COR :
                (e == 1) ? msg_sig_pkg::MSG_ERR_NONFATAL :
                msg_sig_pkg::MSG_ERR_FATAL;
            rx(c);
         end else begin
            err_detected <= ev[2:0];
            @(posedge aclk);
            err_detected <= 3'h0;
            repeat (4) @(posedge aclk);
         end
         chk(34'(serr_out), 34'h1);
         rd(EVT, OK, 32'(ev));
         wr(EVT, ev, OK);
         chk(34'(serr_out), 34'h0);
         chk(34'(irq), 34'h0);
      end
      wrap_up();
   end
endmodule // tb_top
